// File: shifter_pkg.sv
package shifter_pkg;

	localparam int unsigned DATA_W = 16;
	localparam int unsigned RES_W = 32;
	localparam int unsigned EXP_W = 8;
	localparam int unsigned AMT_W = 8;

	// Exponent values used by the detector, the lower derive check and reset, plus the shift array's span.
	localparam logic [7:0] EXP_RESET = 8'hF0;
	localparam logic [7:0] EXP_ALL_SIGN = 8'hF1;
	localparam logic [7:0] EXP_OVERFLOW = 8'h01;
	localparam logic [7:0] EXP_LO_OFFSET = 8'hF0;
	localparam logic [7:0] SHIFT_SPAN = 8'h20;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

	// Operation codes, Gray coded in the order of a typical sequence.
	typedef enum logic [2:0] {
		OP_IDLE = 3'h0,
		OP_ARITH = 3'h1,
		OP_LOGIC = 3'h3,
		OP_DENORM = 3'h2,
		OP_DERIVE = 3'h6,
		OP_LEFT_JUSTIFY_OP = 3'h7,
		OP_BLOCK = 3'h5
	} op_e;

	typedef enum logic [1:0] {
		MODE_HI = 2'h0,
		MODE_LO = 2'h1,
		MODE_HIX = 2'h3
	} mode_e;

	typedef struct packed {
		op_e op;
		mode_e mode;
		logic or_opt;
		logic arith;
		logic [7:0] imm;
		logic [15:0] operand;
	} cmd_s;

	typedef struct packed {
		logic overflow;
		logic carry;
	} flags_s;

	typedef struct packed {
		logic [31:0] result;
		logic [7:0] shift_exp;
		logic [7:0] block_exp;
		logic sign;
		logic done;
	} state_s;

endpackage : shifter_pkg

// File: exponent_detector.sv
`timescale 1ns/10ps
`default_nettype none

module exponent_detector #(
	parameter int unsigned W = 16
) (
	// Operand and context
	input wire logic [W-1:0] operand,
	input wire shifter_pkg::mode_e mode,
	input wire shifter_pkg::flags_s flags,
	input wire logic stored_sign,
	// Detected exponent and sign
	output logic [7:0] exponent,
	output logic sign
);

	logic [7:0] run;
	logic done;

	always_comb begin
		sign = (mode == shifter_pkg::MODE_LO) ? stored_sign : operand[W-1];
		run = 8'h00;
		done = 1'b0;
		for (int i = W - 2; i >= 0; i--) begin
			if (!done && operand[i] == sign) begin
				run = run + 8'h01;
			end else begin
				done = 1'b1;
			end
		end
		exponent = 8'h00 - run;
		if (mode == shifter_pkg::MODE_LO) begin
			// A non-sign MSB leaves no redundant bit in this half, so the total is minus fifteen.
			if (operand[W-1] != sign) begin
				exponent = 8'h01;
			end
			exponent = exponent + shifter_pkg::EXP_LO_OFFSET;
		end
		if (mode == shifter_pkg::MODE_HIX && flags.overflow) begin
			exponent = shifter_pkg::EXP_OVERFLOW;
			sign = ~operand[W-1];
		end
	end

endmodule : exponent_detector

`default_nettype wire

// File: shift_array.sv
`timescale 1ns/10ps
`default_nettype none

module shift_array #(
	parameter int unsigned W = 16
) (
	// Operand and shift control
	input wire logic [W-1:0] operand,
	input wire logic [7:0] amount,
	input wire logic upper,
	input wire logic fill,
	input wire logic ext_bit,
	// Shifted result
	output logic [2*W-1:0] shifted
);

	logic [3*W-1:0] wide;
	logic [7:0] mag;

	always_comb begin
		if (upper) begin
			wide = {{(W-1){fill}}, ext_bit, operand, {W{1'b0}}};
		end else begin
			wide = {{W{fill}}, {(W-1){fill}}, ext_bit, operand};
		end
		mag = amount[7] ? (8'h00 - amount) : amount;
		if (mag >= shifter_pkg::SHIFT_SPAN + 8'h10) begin
			shifted = amount[7] ? {(2*W){fill}} : {(2*W){1'b0}};
		end else if (amount[7]) begin
			shifted = (2*W)'($signed({fill, wide}) >>> mag);
		end else begin
			shifted = (2*W)'(wide << mag);
		end
	end

endmodule : shift_array

`default_nettype wire

// File: barrel_shifter_exponent_unit.sv
// Behaviour
// - Block exponent updates only when detected exponent is strictly greater.
// - Block adjust only inspects; shift result stays unchanged.
// - Immediate shift amount is signed 8-bit; negative right, positive left.
// - Immediate shift neither reads nor changes shift exponent.
// - Upper mode aligns input to upper word, lower mode to lower.
// - Right shift fills sign (arithmetic) or zeros (logical); left fills zeros.
// - Denormalize takes amount from shift exponent register.
// - OR option ORs into result; otherwise result is replaced.
// - Derive stores detected exponent in shift exponent; all three modes.
// - Normalize shifts by negated shift exponent; half modes and OR.
// - Lower derive updates shift exponent only when it holds minus fifteen.
// - Left shift of sixteen or more clears an upper-referenced input.
// - Overflow-extended detect gives plus one when overflow set.
// - Normalize extension bit is carry for upper, zero for lower.
// - Overflow-extended detect equals upper detect when overflow clear.
// - Upper mode yields negated count of redundant sign bits.
// - Lower mode uses stored sign and offsets exponent by minus sixteen.
// - Shift operations deliver 32-bit result in upper and lower words.
`timescale 1ns/10ps
`default_nettype none

module barrel_shifter_exponent_unit #(
	parameter int unsigned DATA_W = shifter_pkg::DATA_W
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Command from the sequencer
	input wire logic cmd_valid,
	input wire shifter_pkg::cmd_s cmd,
	input wire shifter_pkg::flags_s flags,
	// Register loads from the program
	input wire logic shift_exp_load,
	input wire logic [7:0] shift_exp_value,
	input wire logic block_exp_load,
	input wire logic [7:0] block_exp_value,
	// Results and state
	output logic [31:0] shift_result_reg,
	output logic [15:0] result_upper_word,
	output logic [15:0] result_bottom_word,
	output logic [7:0] shift_exponent_reg,
	output logic [7:0] block_exponent_reg,
	output logic shifter_sign,
	output logic done
);

	shifter_pkg::state_s s_q;
	shifter_pkg::state_s s_d;
	logic [7:0] det_exp;
	logic det_sign;
	logic [7:0] amount;
	logic upper;
	logic fill;
	logic ext_bit;
	logic [31:0] shifted;

	exponent_detector #(
		.W(DATA_W)
	) u_detect (
		.operand(cmd.operand),
		.mode(cmd.mode),
		.flags(flags),
		.stored_sign(s_q.sign),
		.exponent(det_exp),
		.sign(det_sign)
	);

	always_comb begin
		upper = (cmd.mode != shifter_pkg::MODE_LO);
		fill = 1'b0;
		ext_bit = cmd.operand[DATA_W-1];
		amount = 8'h00;
		case (cmd.op)
			shifter_pkg::OP_ARITH, shifter_pkg::OP_LOGIC: begin
				amount = cmd.imm;
				fill = (cmd.op == shifter_pkg::OP_ARITH) & cmd.operand[DATA_W-1];
				ext_bit = fill;
			end
			shifter_pkg::OP_DENORM: begin
				amount = s_q.shift_exp;
				fill = cmd.arith & cmd.operand[DATA_W-1];
				ext_bit = fill;
			end
			shifter_pkg::OP_LEFT_JUSTIFY_OP: begin
				amount = 8'h00 - s_q.shift_exp;
				ext_bit = upper ? flags.carry : 1'b0;
				fill = ext_bit;
			end
			default: begin
				amount = 8'h00;
			end
		endcase
	end

	shift_array #(
		.W(DATA_W)
	) u_shift (
		.operand(cmd.operand),
		.amount(amount),
		.upper(upper),
		.fill(fill),
		.ext_bit(ext_bit),
		.shifted(shifted)
	);

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (shift_exp_load) begin
			s_d.shift_exp = shift_exp_value;
		end
		if (block_exp_load) begin
			s_d.block_exp = block_exp_value;
		end
		if (cmd_valid) begin
			s_d.done = 1'b1;
			case (cmd.op)
				shifter_pkg::OP_ARITH, shifter_pkg::OP_LOGIC,
				shifter_pkg::OP_DENORM, shifter_pkg::OP_LEFT_JUSTIFY_OP: begin
					s_d.result = cmd.or_opt ? (s_q.result | shifted) : shifted;
				end
				shifter_pkg::OP_DERIVE: begin
					// Lower updates only after all-sign upper.
					if (cmd.mode != shifter_pkg::MODE_LO) begin
						s_d.shift_exp = det_exp;
						s_d.sign = det_sign;
					end else if (s_q.shift_exp == shifter_pkg::EXP_ALL_SIGN) begin
						s_d.shift_exp = det_exp;
					end
				end
				shifter_pkg::OP_BLOCK: begin
					if ($signed(det_exp) > $signed(s_q.block_exp)) begin
						s_d.block_exp = det_exp;
					end
				end
				default: begin
					s_d.done = 1'b0;
				end
			endcase
		end
	end

	// Register loads lose to a command in the same cycle only for that register.
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '{result: shifter_pkg::RESULT_RESET, shift_exp: 8'h00,
				block_exp: shifter_pkg::EXP_RESET, sign: 1'b0, done: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign shift_result_reg = s_q.result;
	assign result_upper_word = s_q.result[31:16];
	assign result_bottom_word = s_q.result[15:0];
	assign shift_exponent_reg = s_q.shift_exp;
	assign block_exponent_reg = s_q.block_exp;
	assign shifter_sign = s_q.sign;
	assign done = s_q.done;

endmodule : barrel_shifter_exponent_unit

`default_nettype wire

// File: barrel_shifter_exponent_unit_sva.sv
`timescale 1ns/10ps
`default_nettype none
module barrel_shifter_exponent_unit_sva (
	// Inputs from the sequencer
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire shifter_pkg::cmd_s cmd,
	input wire shifter_pkg::flags_s flags,
	input wire logic shift_exp_load,
	input wire logic block_exp_load,
	// Registered outputs
	input wire logic [31:0] shift_result_reg,
	input wire logic [15:0] result_upper_word,
	input wire logic [15:0] result_bottom_word,
	input wire logic [7:0] shift_exponent_reg,
	input wire logic [7:0] block_exponent_reg,
	input wire logic done
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic go, ok, der, imm;
	assign go = ce && cmd_valid;
	assign ok = go && !shift_exp_load;
	assign der = ok && cmd.op == shifter_pkg::OP_DERIVE;
	assign imm = ok && cmd.op inside {shifter_pkg::OP_ARITH, shifter_pkg::OP_LOGIC};
	sequence s_exec;
		go;
	endsequence
	AST_DONE: assert property (s_exec |=> done)
		else $error("done missing");
	AST_WORDS: assert property (go && cmd.op == shifter_pkg::OP_LOGIC && !cmd.or_opt &&
		cmd.mode == shifter_pkg::MODE_LO && cmd.imm == 8'h00 |=> result_upper_word == 16'h0000
		&& result_bottom_word == $past(cmd.operand)) else $error("word split wrong");
	AST_SB_UP: assert property (!block_exp_load |=>
		$signed(block_exponent_reg) >= $signed($past(block_exponent_reg))) else $error("block fell");
	AST_ADJ: assert property (ok && cmd.op == shifter_pkg::OP_BLOCK |=>
		$stable(shift_result_reg) && $stable(shift_exponent_reg)) else $error("adjust wrote");
	AST_IMM_SE: assert property (imm |=> $stable(shift_exponent_reg))
		else $error("immediate moved exponent");
	AST_LO_KEEP: assert property (der && cmd.mode == shifter_pkg::MODE_LO &&
		shift_exponent_reg != 8'hF1 |=> $stable(shift_exponent_reg)) else $error("low derive wrote");
	AST_HIX: assert property (der && cmd.mode == shifter_pkg::MODE_HIX && flags.overflow |=>
		shift_exponent_reg == 8'h01) else $error("overflow exponent wrong");
	AST_OR: assert property (go && cmd.or_opt && cmd.op inside {shifter_pkg::OP_DENORM,
		shifter_pkg::OP_LEFT_JUSTIFY_OP} |=> ($past(shift_result_reg) & ~shift_result_reg) == 32'h0)
		else $error("or cleared bits");
endmodule : barrel_shifter_exponent_unit_sva
`default_nettype wire

// File: alu_status_model.sv
`timescale 1ns/10ps
`default_nettype none
module alu_status_model (
	// Clock and update request
	input wire logic clk,
	input wire logic srst,
	input wire logic set,
	input wire shifter_pkg::flags_s value,
	// Flags towards the shifter
	output var shifter_pkg::flags_s flags
);
	// Flags move only on an edge, so a command never sees them change mid-cycle.
	always_ff @(posedge clk) begin
		if (srst) begin
			flags <= '0;
		end else if (set) begin
			flags <= value;
		end
	end
endmodule : alu_status_model
`default_nettype wire

// File: barrel_shifter_exponent_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module barrel_shifter_exponent_unit_tb;
	logic clk = 1'b0, srst = 1'b1, ce = 1'b1, cmd_valid = 1'b0, fset = 1'b0;
	logic shift_exp_load = 1'b0, block_exp_load = 1'b0, shifter_sign, done;
	logic [7:0] shift_exp_value = 8'h00, block_exp_value = 8'h00;
	logic [7:0] shift_exponent_reg, block_exponent_reg;
	logic [15:0] result_upper_word, result_bottom_word;
	logic [31:0] shift_result_reg;
	shifter_pkg::cmd_s cmd = '0;
	shifter_pkg::flags_s fval = '0, flags;
	int errors = 0, checked = 0, cyc = 0, tn = 0;
	initial forever #4 clk = ~clk;
	alu_status_model partner (.clk(clk), .srst(srst), .set(fset), .value(fval), .flags(flags));
	barrel_shifter_exponent_unit dut (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.cmd_valid(cmd_valid),
		.cmd(cmd),
		.flags(flags),
		.shift_exp_load(shift_exp_load),
		.shift_exp_value(shift_exp_value),
		.block_exp_load(block_exp_load),
		.block_exp_value(block_exp_value),
		.shift_result_reg(shift_result_reg),
		.result_upper_word(result_upper_word),
		.result_bottom_word(result_bottom_word),
		.shift_exponent_reg(shift_exponent_reg),
		.block_exponent_reg(block_exponent_reg),
		.shifter_sign(shifter_sign),
		.done(done)
	);
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic cmp(logic [31:0] g, logic [31:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask : cmp
	task automatic tend();
		tn++;
		$display("test %0d done", tn);
	endtask : tend
	// Each command is checked at the next negedge, then followed by an idle cycle so done drops again.
	task automatic op(logic [2:0] o, logic [1:0] m, logic r, logic [15:0] d, logic [7:0] i,
		logic [31:0] e);
		cmd_valid = 1'b1;
		cmd = '{shifter_pkg::op_e'(o), shifter_pkg::mode_e'(m), r, m != 2'h1, i, d};
		@(negedge clk);
		cmd_valid = 1'b0;
		cmp({31'h0, done}, 32'h1);
		if (o == 3'h6) begin
			cmp(32'(shift_exponent_reg), e);
		end else if (o == 3'h5) begin
			cmp(32'(block_exponent_reg), e);
		end else begin
			cmp(shift_result_reg, e);
		end
		@(negedge clk);
	endtask : op
	task automatic ld(logic s, logic [7:0] v);
		shift_exp_load = s;
		block_exp_load = !s;
		shift_exp_value = v;
		block_exp_value = v;
		@(negedge clk);
		shift_exp_load = 1'b0;
		block_exp_load = 1'b0;
		@(negedge clk);
	endtask : ld
	task automatic fl(logic v, logic c);
		fset = 1'b1;
		fval = '{v, c};
		@(negedge clk);
		fset = 1'b0;
		@(negedge clk);
	endtask : fl
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		srst = 1'b0;
		cmp(shift_result_reg, 32'h0);
		cmp(32'(block_exponent_reg), 32'hF0);
		tend();
		ld(1'b1, 8'h7D);
		op(3'h3, 2'h0, 1'b0, 16'hB6A3, 8'hFB, 32'h05B51800);
		op(3'h3, 2'h1, 1'b0, 16'hB6A3, 8'h05, 32'h0016D460);
		op(3'h1, 2'h0, 1'b0, 16'hB6A3, 8'hFB, 32'hFDB51800);
		op(3'h3, 2'h1, 1'b0, 16'h8001, 8'h00, 32'h00008001);
		// A command offered while the enable is low must leave all state frozen.
		ce = 1'b0;
		cmd_valid = 1'b1;
		cmd.operand = 16'hFFFF;
		@(negedge clk);
		ce = 1'b1;
		cmd_valid = 1'b0;
		cmp(shift_result_reg, 32'h00008001);
		cmp({31'h0, done}, 32'h0);
		cmp(32'(shift_exponent_reg), 32'h7D);
		tend();
		ld(1'b1, 8'hFD);
		op(3'h2, 2'h0, 1'b0, 16'hB6A3, 8'h00, 32'hF6D46000);
		op(3'h2, 2'h1, 1'b1, 16'h765D, 8'h00, 32'hF6D46ECB);
		tend();
		op(3'h6, 2'h0, 1'b0, 16'hFFFF, 8'h00, 32'hF1);
		op(3'h6, 2'h1, 1'b0, 16'hF6D4, 8'h00, 32'hED);
		op(3'h7, 2'h0, 1'b0, 16'hFFFF, 8'h00, 32'h0);
		op(3'h6, 2'h0, 1'b0, 16'hF6D4, 8'h00, 32'hFD);
		cmp({31'h0, shifter_sign}, 32'h1);
		op(3'h6, 2'h1, 1'b0, 16'h6ECB, 8'h00, 32'hFD);
		op(3'h7, 2'h0, 1'b0, 16'hF6D4, 8'h00, 32'hB6A00000);
		op(3'h7, 2'h1, 1'b1, 16'h6ECB, 8'h00, 32'hB6A37658);
		tend();
		fl(1'b1, 1'b0);
		op(3'h6, 2'h3, 1'b0, 16'hFA32, 8'h00, 32'h01);
		cmp({31'h0, shifter_sign}, 32'h0);
		op(3'h7, 2'h0, 1'b0, 16'hFA32, 8'h00, 32'h7D190000);
		fl(1'b0, 1'b0);
		op(3'h6, 2'h3, 1'b0, 16'hE35B, 8'h00, 32'hFE);
		tend();
		ld(1'b0, 8'hF0);
		op(3'h5, 2'h0, 1'b0, 16'hF5B1, 8'h00, 32'hFD);
		op(3'h5, 2'h0, 1'b0, 16'h0176, 8'h00, 32'hFD);
		tend();
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		cmp(shift_result_reg, 32'h0);
		cmp(32'(shift_exponent_reg), 32'h0);
		cmp(32'(block_exponent_reg), 32'hF0);
		tend();
		end_of_test();
	end
endmodule : barrel_shifter_exponent_unit_tb
bind barrel_shifter_exponent_unit barrel_shifter_exponent_unit_sva sva (
	.clk(clk),
	.srst(srst),
	.ce(ce),
	.cmd_valid(cmd_valid),
	.cmd(cmd),
	.flags(flags),
	.shift_exp_load(shift_exp_load),
	.block_exp_load(block_exp_load),
	.shift_result_reg(shift_result_reg),
	.result_upper_word(result_upper_word),
	.result_bottom_word(result_bottom_word),
	.shift_exponent_reg(shift_exponent_reg),
	.block_exponent_reg(block_exponent_reg),
	.done(done)
);
`default_nettype wire
